// >>> bench/testbench.sv
// Purpose: Self-checking bench for the baud clock selection block
// Assumes: Zero-wait AHB-Lite slave, timer one modelled as a pulse every 5 clocks
// Notes: Tick periods are measured on the second interval to skip halving phase
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [11:0] ctrl; logic [7:0] intgen_reload_value; logic [15:0] rld; int idx; int per;} ubc_case_s;
    logic hclk, hresetn, hsel, hwrite, t1_overflow, ext_pin, cnt_pin, clr, rx_resync;
    logic hreadyout, hresp, irq, tx_st, tx_bt, rx_st, rx_bt, m0_tick;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] tx_samp_cnt, rx_samp_cnt;
    logic [4:0] tk;
    int err_total, tests_run, cyc, t1_cnt, t1_len, p;
    ubc_case_s cases [11];

    assign tk = {rx_bt, tx_bt, m0_tick, rx_st, tx_st};

    ubc_baud_sel i_ubc_baud_sel (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .t1_overflow(t1_overflow), .t2_external_pin(ext_pin), .t2_count_pin(cnt_pin),
        .rx_resync(rx_resync), .tx_sample_tick(tx_st), .tx_bit_tick(tx_bt),
        .rx_sample_tick(rx_st), .rx_bit_tick(rx_bt), .mode0_tick(m0_tick), .irq(irq)
    );

    ubc_uart_model i_ubc_uart_model (
        .hclk(hclk), .hresetn(hresetn), .tx_sample_tick(tx_st), .rx_sample_tick(rx_st),
        .clr(clr), .rx_resync(rx_resync), .tx_samp_cnt(tx_samp_cnt),
        .rx_samp_cnt(rx_samp_cnt)
    );

    initial begin
        hclk = 1'b0;
    end
    always #12.5 hclk = ~hclk;

    // Timer one in auto-reload use: a steady overflow train, its interrupt unused
    // A longer t1_len stands for a 16-bit timer reloaded by software
    always @(posedge hclk) begin
        t1_cnt <= (t1_cnt == t1_len) ? 0 : t1_cnt + 1;
        t1_overflow <= hresetn && (t1_cnt == t1_len);
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Generous ceiling; the whole sequence needs well under 10000 cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single transfer; read data taken at the edge that ends the data phase
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h00000000);
        chk(rd, exp);
    endtask

    // Two ticks are skipped so a stale tick from the old setting is never timed
    task automatic period(input int i, output int n);
        repeat (2) begin
            do @(posedge hclk); while (tk[i] !== 1'b1);
        end
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (tk[i] !== 1'b1);
    endtask

    task automatic pulse_clr();
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        ext_pin = 1'b1;
        cnt_pin = 1'b1;
        clr = 1'b0;
        t1_overflow = 1'b0;
        t1_cnt = 0;
        t1_len = 4;
        cyc = 0;
        err_total = 0;
        tests_run = 0;
        cases[0] = '{12'h000, 8'h00, 16'h0000, 0, 10};
        cases[1] = '{12'h040, 8'h00, 16'h0000, 1, 5};
        cases[2] = '{12'h035, 8'hFC, 16'h0000, 0, 4};
        cases[3] = '{12'h016, 8'hFC, 16'h0000, 1, 8};
        cases[4] = '{12'h032, 8'hFE, 16'h0000, 1, 12};
        cases[5] = '{12'h03C, 8'hF0, 16'h0000, 2, 16};
        cases[6] = '{12'h000, 8'h00, 16'h0000, 2, 6};
        cases[7] = '{12'h280, 8'h00, 16'hFFFC, 0, 8};
        cases[8] = '{12'h300, 8'h00, 16'hFFF0, 1, 32};
        cases[9] = '{12'h2B5, 8'hFA, 16'hFFFC, 0, 6};
        cases[10] = '{12'h280, 8'h00, 16'h0000, 1, 10};
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(ubc_pkg::CTRL_OFS, 32'h00000000);
        rd_chk(ubc_pkg::BRL_OFS, 32'h00000000);
        rd_chk(ubc_pkg::T2RLD_OFS, 32'h00000000);
        rd_chk(ubc_pkg::STAT_OFS, 32'h00000000);
        rd_chk(ubc_pkg::IEN_OFS, 32'h00000000);
        chk({31'h00000000, hresp}, 32'h00000000);
        foreach (cases[k]) begin
            bus(ubc_pkg::CTRL_OFS, 1'b1, 32'h00000000);
            bus(ubc_pkg::BRL_OFS, 1'b1, {24'h000000, cases[k].intgen_reload_value});
            bus(ubc_pkg::T2RLD_OFS, 1'b1, {16'h0000, cases[k].rld});
            bus(ubc_pkg::T2CNT_OFS, 1'b1, {16'h0000, cases[k].rld});
            bus(ubc_pkg::CTRL_OFS, 1'b1, {20'h00000, cases[k].ctrl});
            rd_chk(ubc_pkg::CTRL_OFS, {20'h00000, cases[k].ctrl});
            period(cases[k].idx, p);
            chk(p, cases[k].per);
        end
        // Baud-mode rollovers above must have left the overflow flag clear
        rd_chk(ubc_pkg::STAT_OFS, 32'h00000000);
        bus(ubc_pkg::CTRL_OFS, 1'b1, 32'h00000040);
        period(3, p);
        chk(p, 32'h00000050);
        period(4, p);
        chk(p, 32'h00000050);
        // Resync away from a source pulse; the bit tick comes with the 16th sample
        do @(posedge hclk); while (rx_st !== 1'b1);
        pulse_clr();
        do @(posedge hclk); while (rx_bt !== 1'b1);
        chk({16'h0000, rx_samp_cnt}, 32'h0000000F);
        chk({16'h0000, tx_samp_cnt}, 32'h0000000F);
        bus(ubc_pkg::IEN_OFS, 1'b1, 32'h00000001);
        bus(ubc_pkg::T2CNT_OFS, 1'b1, 32'h00001234);
        bus(ubc_pkg::CTRL_OFS, 1'b1, 32'h00000880);
        ext_pin <= 1'b0;
        repeat (6) @(posedge hclk);
        chk({31'h00000000, irq}, 32'h00000001);
        rd_chk(ubc_pkg::STAT_OFS, 32'h00000001);
        rd_chk(ubc_pkg::T2CNT_OFS, 32'h00001234);
        bus(ubc_pkg::ICLR_OFS, 1'b1, 32'h00000001);
        @(posedge hclk);
        chk({31'h00000000, irq}, 32'h00000000);
        bus(ubc_pkg::T2CNT_OFS, 1'b1, 32'h0000FFFF);
        bus(ubc_pkg::CTRL_OFS, 1'b1, 32'h00000200);
        repeat (30) @(posedge hclk);
        rd_chk(ubc_pkg::STAT_OFS, 32'h00000002);
        chk({31'h00000000, irq}, 32'h00000000);
        bus(ubc_pkg::CTRL_OFS, 1'b1, 32'h00000000);
        bus(ubc_pkg::T2CNT_OFS, 1'b1, 32'h00000000);
        bus(ubc_pkg::CTRL_OFS, 1'b1, 32'h00000600);
        repeat (3) begin
            cnt_pin <= 1'b0;
            repeat (4) @(posedge hclk);
            cnt_pin <= 1'b1;
            repeat (4) @(posedge hclk);
        end
        rd_chk(ubc_pkg::T2CNT_OFS, 32'h00000003);
        t1_len <= 9;
        bus(ubc_pkg::CTRL_OFS, 1'b1, 32'h00000040);
        period(0, p);
        chk(p, 32'h0000000A);
        test_done();
    end
endmodule // testbench

// >>> bench/ubc_uart_model.sv
// Purpose: Stand-in for the serial transmitter and receiver bit timing
// Assumes: All ticks are one-cycle pulses on hclk
// Notes: clr restarts receive bit timing, as a detected start edge would
`timescale 1ns/1ps
module ubc_uart_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Ticks from the block
    input wire logic tx_sample_tick,
    input wire logic rx_sample_tick,
    // Control from the bench
    input wire logic clr,
    // Towards the block
    output logic rx_resync,
    // Observed counts
    output logic [15:0] tx_samp_cnt,
    output logic [15:0] rx_samp_cnt
);
    // A start edge only lasts one cycle, so the resync mirrors the clear pulse
    assign rx_resync = clr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_samp_cnt <= 16'h0000;
            rx_samp_cnt <= 16'h0000;
        end else if (clr) begin
            tx_samp_cnt <= 16'h0000;
            rx_samp_cnt <= 16'h0000;
        end else begin
            tx_samp_cnt <= tx_samp_cnt + {15'h0000, tx_sample_tick};
            rx_samp_cnt <= rx_samp_cnt + {15'h0000, rx_sample_tick};
        end
    end
endmodule // ubc_uart_model

// >>> design/ubc_baud_sel.sv
// Purpose: Serial baud clock sourcing with timer two baud generator
// Assumes: t1_overflow and rx_resync come from logic on hclk
// Notes: Registers reached over AHB-Lite, zero wait states
`timescale 1ns/1ps
// What this block does
// - Internal generator, then timer two, then one
// - Generator rate uses doubling, speed, reload value
// - Generator overflow sets rate when selected
// - Generator serves async modes and mode zero
// - Timer one rate halved unless doubling set
// - Either timer two select enables baud mode
// - Timer two rollover reloads from reload registers in baud mode, else clears to zero
// - Baud timer two counts every state time
// - Baud rollover never sets overflow flag
// - External falling edge sets flag, no reload
// - Timer two may count timer or counter
// - Receiver samples at sixteen times baud rate
module ubc_baud_sel (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Timer sources and pins
    input wire logic t1_overflow,
    input wire logic t2_external_pin,
    input wire logic t2_count_pin,
    input wire logic rx_resync,
    // Baud ticks
    output logic tx_sample_tick,
    output logic tx_bit_tick,
    output logic rx_sample_tick,
    output logic rx_bit_tick,
    output logic mode0_tick,
    // Interrupt
    output logic irq
);
    localparam int CW = ubc_pkg::CTRL_W;
    localparam int SW = ubc_pkg::ST_W;

    // Returns {tick, halve} for one direction
    function automatic logic [1:0] pick_src(input logic ig_sel, input logic t2_sel,
            input logic ig_tick, input logic t2_tick, input logic t1_tick,
            input logic ig_dbl, input logic t1_dbl);
        if (ig_sel) begin
            pick_src = {ig_tick, !ig_dbl};
        end else if (t2_sel) begin
            pick_src = {t2_tick, 1'b0};
        end else begin
            pick_src = {t1_tick, !t1_dbl};
        end
    endfunction

    logic acc, wr_en_r, wr_en_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [CW-1:0] ctrl_r, ctrl_nxt;
    logic [7:0] brl_r, brl_nxt;
    logic [15:0] rld_r, rld_nxt;
    logic [15:0] t2_cnt_r, t2_cnt_nxt;
    logic [SW-1:0] status_r, status_nxt, ien_r, ien_nxt, st_set, st_clr;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic t2_ovf_r, t2_ovf_nxt, t2_wr, baud_mode, t2_inc, t2_roll;
    logic ext_s1_r, ext_s2_r, ext_s3_r, cnt_s1_r, cnt_s2_r, cnt_s3_r;
    logic ext_fall, cnt_fall;
    logic [3:0] pre_r, pre_nxt;
    logic state_tick, mach_tick, fixed0_tick;
    logic mode0_r, mode0_nxt, ig_ovf;
    logic [1:0] tx_pick, rx_pick;

    // Register file and bus slave
    always_comb begin
        acc = hsel && htrans[1] && hready;
        wr_en_nxt = acc && hwrite;
        addr_nxt = acc ? haddr[7:0] : addr_r;
        ctrl_nxt = ctrl_r;
        brl_nxt = brl_r;
        rld_nxt = rld_r;
        ien_nxt = ien_r;
        st_clr = '0;
        if (wr_en_r) begin
            case (addr_r)
                ubc_pkg::CTRL_OFS: ctrl_nxt = hwdata[CW-1:0];
                ubc_pkg::BRL_OFS: brl_nxt = hwdata[7:0];
                ubc_pkg::T2RLD_OFS: rld_nxt = hwdata[15:0];
                ubc_pkg::IEN_OFS: ien_nxt = hwdata[SW-1:0];
                ubc_pkg::ICLR_OFS: st_clr = hwdata[SW-1:0];
                default: st_clr = '0;
            endcase
        end
        // A flag raised in the clearing cycle survives
        status_nxt = (status_r & ~st_clr) | st_set;
        hrdata_nxt = hrdata_r;
        if (acc && !hwrite) begin
            case (haddr[7:0])
                ubc_pkg::CTRL_OFS: hrdata_nxt = {20'h00000, ctrl_nxt};
                ubc_pkg::BRL_OFS: hrdata_nxt = {24'h000000, brl_nxt};
                ubc_pkg::T2RLD_OFS: hrdata_nxt = {16'h0000, rld_nxt};
                ubc_pkg::T2CNT_OFS: hrdata_nxt = {16'h0000, t2_cnt_nxt};
                ubc_pkg::STAT_OFS: hrdata_nxt = {30'h00000000, status_nxt};
                ubc_pkg::IEN_OFS: hrdata_nxt = {30'h00000000, ien_nxt};
                default: hrdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_en_r <= 1'b0;
            addr_r <= 8'h00;
            ctrl_r <= ubc_pkg::CTRL_RST;
            brl_r <= ubc_pkg::BRL_RST;
            rld_r <= ubc_pkg::T2_RST;
            ien_r <= ubc_pkg::ST_RST;
            status_r <= ubc_pkg::ST_RST;
            hrdata_r <= 32'h00000000;
        end else if (ce) begin
            wr_en_r <= wr_en_nxt;
            addr_r <= addr_nxt;
            ctrl_r <= ctrl_nxt;
            brl_r <= brl_nxt;
            rld_r <= rld_nxt;
            ien_r <= ien_nxt;
            status_r <= status_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign irq = |(status_r & ien_r);

    // Pin synchronisers; edges are taken only from the settled stages
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_s1_r <= 1'b1;
            ext_s2_r <= 1'b1;
            ext_s3_r <= 1'b1;
            cnt_s1_r <= 1'b1;
            cnt_s2_r <= 1'b1;
            cnt_s3_r <= 1'b1;
        end else if (ce) begin
            ext_s1_r <= t2_external_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            cnt_s1_r <= t2_count_pin;
            cnt_s2_r <= cnt_s1_r;
            cnt_s3_r <= cnt_s2_r;
        end
    end

    // State-time and machine-cycle prescaler
    always_comb begin
        state_tick = pre_r[0];
        mach_tick = pre_r == ubc_pkg::MACH_DIV - 4'h1;
        fixed0_tick = pre_r == ubc_pkg::MODE0_DIV - 4'h1 || mach_tick;
        pre_nxt = mach_tick ? 4'h0 : pre_r + 4'h1;
        mode0_nxt = ctrl_r[ubc_pkg::MODE0_SRC] ? ig_ovf : fixed0_tick;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_r <= 4'h0;
            mode0_r <= 1'b0;
        end else if (ce) begin
            pre_r <= pre_nxt;
            mode0_r <= mode0_nxt;
        end
    end

    assign mode0_tick = mode0_r;

    // Timer two
    always_comb begin
        baud_mode = ctrl_r[ubc_pkg::T2_TX] || ctrl_r[ubc_pkg::T2_RX];
        ext_fall = ext_s3_r && !ext_s2_r;
        cnt_fall = cnt_s3_r && !cnt_s2_r;
        t2_wr = wr_en_r && addr_r == ubc_pkg::T2CNT_OFS;
        t2_inc = ctrl_r[ubc_pkg::T2_RUN] && (ctrl_r[ubc_pkg::T2_CT] ? cnt_fall
            : (baud_mode ? state_tick : mach_tick));
        t2_roll = t2_inc && t2_cnt_r == 16'hFFFF;
        t2_cnt_nxt = t2_cnt_r;
        t2_ovf_nxt = 1'b0;
        st_set = '0;
        // A count write wins over the increment in the same cycle; software stops the timer first
        if (t2_wr) begin
            t2_cnt_nxt = hwdata[15:0];
        end else if (t2_roll) begin
            if (baud_mode) begin
                t2_cnt_nxt = rld_r;
                t2_ovf_nxt = 1'b1;
            end else begin
                t2_cnt_nxt = 16'h0000;
                st_set[ubc_pkg::ST_OVF] = 1'b1;
            end
        end else if (t2_inc) begin
            t2_cnt_nxt = t2_cnt_r + 16'h0001;
        end
        // No reload from the external edge, only the flag
        st_set[ubc_pkg::ST_EXT] = ctrl_r[ubc_pkg::T2_EXEN] && ext_fall;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            t2_cnt_r <= ubc_pkg::T2_RST;
            t2_ovf_r <= 1'b0;
        end else if (ce) begin
            t2_cnt_r <= t2_cnt_nxt;
            t2_ovf_r <= t2_ovf_nxt;
        end
    end

    ubc_intgen u_intgen (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .run(ctrl_r[ubc_pkg::IG_RUN]),
        .speed(ctrl_r[ubc_pkg::IG_SPEED]),
        .reload(brl_r),
        .ovf(ig_ovf)
    );

    // Source selection per direction
    always_comb begin
        tx_pick = pick_src(ctrl_r[ubc_pkg::IG_TX], ctrl_r[ubc_pkg::T2_TX], ig_ovf,
            t2_ovf_r, t1_overflow, ctrl_r[ubc_pkg::RATE_DBL], ctrl_r[ubc_pkg::SER_DBL]);
        rx_pick = pick_src(ctrl_r[ubc_pkg::IG_RX], ctrl_r[ubc_pkg::T2_RX], ig_ovf,
            t2_ovf_r, t1_overflow, ctrl_r[ubc_pkg::RATE_DBL], ctrl_r[ubc_pkg::SER_DBL]);
    end

    // Halving stage gives the rate doubling for timer one and the generator
    ubc_ovs_div u_tx_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .tick_in(tx_pick[1]),
        .halve(tx_pick[0]),
        .resync(1'b0),
        .sample_tick(tx_sample_tick),
        .bit_tick(tx_bit_tick)
    );

    ubc_ovs_div u_rx_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .tick_in(rx_pick[1]),
        .halve(rx_pick[0]),
        .resync(rx_resync),
        .sample_tick(rx_sample_tick),
        .bit_tick(rx_bit_tick)
    );

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_tx_t1;
        ce && !ctrl_r[ubc_pkg::IG_TX] && !ctrl_r[ubc_pkg::T2_TX] |-> tx_pick[1] == t1_overflow;
    endproperty
    a_tx_t1: assert property (p_tx_t1)
        else $error("transmit source not timer one");

    property p_rx_ig;
        ce && ctrl_r[ubc_pkg::IG_RX] |-> rx_pick == {ig_ovf, !ctrl_r[ubc_pkg::RATE_DBL]};
    endproperty
    a_rx_ig: assert property (p_rx_ig)
        else $error("receive source not internal generator");

    property p_t2_reload;
        ce && baud_mode && t2_roll && !t2_wr |=> t2_ovf_r && t2_cnt_r == $past(rld_r);
    endproperty
    a_t2_reload: assert property (p_t2_reload)
        else $error("timer two did not reload on rollover");

    property p_no_ovf_flag;
        ce && baud_mode && t2_roll |=> !$rose(status_r[ubc_pkg::ST_OVF]);
    endproperty
    a_no_ovf_flag: assert property (p_no_ovf_flag)
        else $error("overflow flag set in baud mode");

    property p_ext_flag;
        ce && ctrl_r[ubc_pkg::T2_EXEN] && ext_fall |=> status_r[ubc_pkg::ST_EXT]
            && (irq || !ien_r[ubc_pkg::ST_EXT]);
    endproperty
    a_ext_flag: assert property (p_ext_flag)
        else $error("external edge did not raise flag");

    property p_ext_noreload;
        ce && ext_fall && !t2_inc && !t2_wr |=> $stable(t2_cnt_r);
    endproperty
    a_ext_noreload: assert property (p_ext_noreload)
        else $error("external edge changed timer two");

    property p_state_rate;
        ce && baud_mode && ctrl_r[ubc_pkg::T2_RUN] && !ctrl_r[ubc_pkg::T2_CT] |-> t2_inc == pre_r[0];
    endproperty
    a_state_rate: assert property (p_state_rate)
        else $error("baud timer two not at state rate");

    property p_t2_baud_mode;
        ce && ctrl_r[ubc_pkg::T2_RX] && !ctrl_r[ubc_pkg::IG_RX] && t2_ovf_r |-> rx_pick == 2'b10;
    endproperty
    a_t2_baud_mode: assert property (p_t2_baud_mode)
        else $error("timer two receive tick not passed unhalved");
endmodule // ubc_baud_sel

// >>> design/ubc_intgen.sv
// Purpose: Internal 8-bit reload baud generator
// Assumes: ce freezes all state
// Notes: One ovf pulse per counter rollover
`timescale 1ns/1ps
module ubc_intgen (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Control
    input wire logic run,
    input wire logic speed,
    input wire logic [7:0] reload,
    // Tick
    output logic ovf
);
    logic [2:0] pre_r, pre_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic ovf_r, ovf_nxt;
    logic step;

    always_comb begin
        step = run && (speed || pre_r == ubc_pkg::SLOW_DIV - 3'h1);
        pre_nxt = pre_r;
        if (!run || step) begin
            pre_nxt = 3'h0;
        end else begin
            pre_nxt = pre_r + 3'h1;
        end
        cnt_nxt = cnt_r;
        ovf_nxt = 1'b0;
        if (step) begin
            if (cnt_r == 8'hFF) begin
                cnt_nxt = reload;
                ovf_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_r <= 3'h0;
            cnt_r <= ubc_pkg::BRL_RST;
            ovf_r <= 1'b0;
        end else if (ce) begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    assign ovf = ovf_r;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ig_reload;
        ce && step && cnt_r == 8'hFF |=> ovf && cnt_r == $past(reload);
    endproperty
    a_ig_reload: assert property (p_ig_reload)
        else $error("generator did not reload on rollover");

    property p_ig_slow;
        ce && run && !speed && pre_r != ubc_pkg::SLOW_DIV - 3'h1 |=> !ovf;
    endproperty
    a_ig_slow: assert property (p_ig_slow)
        else $error("slow generator stepped early");
endmodule // ubc_intgen

// >>> design/ubc_ovs_div.sv
// Purpose: Optional halving, 16x sample tick and divide-by-16 bit tick
// Assumes: tick_in is a one-cycle pulse on hclk
// Notes: resync restarts bit timing for receive start detection
`timescale 1ns/1ps
module ubc_ovs_div (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Source
    input wire logic tick_in,
    input wire logic halve,
    input wire logic resync,
    // Ticks
    output logic sample_tick,
    output logic bit_tick
);
    logic half_r, half_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic smp_r, smp_nxt;
    logic bit_r, bit_nxt;

    always_comb begin
        half_nxt = half_r;
        cnt_nxt = cnt_r;
        smp_nxt = tick_in && (!halve || half_r);
        bit_nxt = smp_nxt && cnt_r == ubc_pkg::OVS_LAST;
        if (tick_in && halve) begin
            half_nxt = !half_r;
        end
        if (smp_nxt) begin
            cnt_nxt = cnt_r + 4'h1;
        end
        if (resync) begin
            half_nxt = 1'b0;
            cnt_nxt = 4'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_r <= 1'b0;
            cnt_r <= 4'h0;
            smp_r <= 1'b0;
            bit_r <= 1'b0;
        end else if (ce) begin
            half_r <= half_nxt;
            cnt_r <= cnt_nxt;
            smp_r <= smp_nxt;
            bit_r <= bit_nxt;
        end
    end

    assign sample_tick = smp_r;
    assign bit_tick = bit_r;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_bit_16;
        ce && !resync && tick_in && !halve && cnt_r == ubc_pkg::OVS_LAST |=> bit_tick && sample_tick;
    endproperty
    a_bit_16: assert property (p_bit_16)
        else $error("bit tick missing at sixteenth sample");
endmodule // ubc_ovs_div

// >>> design/ubc_pkg.sv
// Purpose: Shared constants for the serial baud clock selection block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Offsets are byte addresses within the block window
package ubc_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] BRL_OFS = 8'h04;
    localparam logic [7:0] T2RLD_OFS = 8'h08;
    localparam logic [7:0] T2CNT_OFS = 8'h0C;
    localparam logic [7:0] STAT_OFS = 8'h10;
    localparam logic [7:0] IEN_OFS = 8'h14;
    localparam logic [7:0] ICLR_OFS = 8'h18;
    // Control register fields
    localparam int IG_TX = 0;
    localparam int IG_RX = 1;
    localparam int IG_SPEED = 2;
    localparam int MODE0_SRC = 3;
    localparam int IG_RUN = 4;
    localparam int RATE_DBL = 5;
    localparam int SER_DBL = 6;
    localparam int T2_TX = 7;
    localparam int T2_RX = 8;
    localparam int T2_RUN = 9;
    localparam int T2_CT = 10;
    localparam int T2_EXEN = 11;
    localparam int CTRL_W = 12;
    // Status, enable and clear fields
    localparam int ST_EXT = 0;
    localparam int ST_OVF = 1;
    localparam int ST_W = 2;
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
    localparam logic [7:0] BRL_RST = 8'h00;
    localparam logic [15:0] T2_RST = 16'h0000;
    localparam logic [ST_W-1:0] ST_RST = 2'h0;
    // Cycle counts
    localparam logic [3:0] STATE_DIV = 4'h2;
    localparam logic [3:0] MACH_DIV = 4'hC;
    localparam logic [3:0] MODE0_DIV = 4'h6;
    localparam logic [2:0] SLOW_DIV = 3'h6;
    localparam logic [3:0] OVS_LAST = 4'hF;
endpackage
